// ==== src/dmra_pkg.sv ====
// package for the mode register bank and attenuator ramp
// assumes one 100 MHz system clock and a sample-rate strobe from the audio side
package dmra_pkg;
    // control word layout
    localparam int WORD_BITS      = 16;
    localparam int IDX_MSB        = 14;
    localparam int IDX_LSB        = 8;
    localparam int TOP_BIT        = 15;
    // register indices
    localparam logic [6:0] IDX_LEFT_LEVEL  = 7'h10;
    localparam logic [6:0] IDX_RIGHT_LEVEL = 7'h11;
    localparam logic [6:0] IDX_MUTE        = 7'h12;
    localparam logic [6:0] IDX_DEEMPH      = 7'h13;
    localparam logic [6:0] IDX_FORMAT      = 7'h14;
    localparam logic [6:0] IDX_RANGE       = 7'h15;
    localparam logic [6:0] IDX_PHASE       = 7'h16;
    // reset values
    localparam logic [7:0] RST_LEVEL  = 8'hff;
    localparam logic [7:0] RST_MUTE   = 8'h00;
    localparam logic [7:0] RST_DEEMPH = 8'h00;
    localparam logic [7:0] RST_FORMAT = 8'h05;
    localparam logic [7:0] RST_RANGE  = 8'h00;
    localparam logic [7:0] RST_PHASE  = 8'h00;
    // writable bit masks, reserved bits hold zero
    localparam logic [7:0] MASK_MUTE   = 8'hc3;
    localparam logic [7:0] MASK_DEEMPH = 8'h73;
    localparam logic [7:0] MASK_FORMAT = 8'h27;
    localparam logic [7:0] MASK_RANGE  = 8'h01;
    localparam logic [7:0] MASK_PHASE  = 8'h07;
    // field positions
    localparam int MUTE_LEFT_BIT   = 0;
    localparam int MUTE_RIGHT_BIT  = 1;
    localparam int OVER_BIT        = 6;
    localparam int REINIT_BIT      = 7;
    // mute thresholds: codes at or below are infinite attenuation
    localparam logic [7:0] FINE_MUTE_TOP = 8'h80;
    localparam logic [7:0] WIDE_MUTE_TOP = 8'h9a;
    // ramp pacing in sample periods and soft reinit length in clocks
    localparam int RAMP_SAMPLES   = 8;
    localparam int REINIT_CLOCKS  = 1024;
endpackage

// ==== src/dmra_ramp.sv ====
// one channel of the attenuator ramp with soft mute folded in
// assumes a one-cycle sample strobe per sample period
`timescale 1ns/1ps
module dmra_ramp
    import dmra_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sample_tick,    // one pulse per sample period
    input  wire logic [7:0] target_code,    // programmed level code
    input  wire logic       silence,        // soft mute request
    input  wire logic       wide_range,     // range select
    output logic      [7:0] applied_code,   // code in effect now
    output logic            applied_mute,   // infinite attenuation now
    output logic            ramping         // not yet at goal
);
    ////////////////////////////////////////////////////////////////
    logic [2:0] pace;          // sample counter between steps
    logic [7:0] goal;          // where the ramp is heading
    logic [7:0] floor_code;    // highest code that means mute

    // the mute floor depends on range; ramping to it is a full mute
    always_comb begin
        floor_code = wide_range ? WIDE_MUTE_TOP : FINE_MUTE_TOP;
        goal       = silence ? floor_code : target_code;
        if (!silence && target_code < floor_code) begin
            goal = floor_code;
        end
    end

    assign ramping      = (applied_code != goal) && !(goal == floor_code && applied_code <= floor_code);
    assign applied_mute = applied_code <= floor_code;

    // sample pacing, restarted while idle so a new ramp waits 8 samples
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pace <= 3'h0;
        end else if (!ramping) begin
            pace <= 3'h0;
        end else if (sample_tick) begin
            pace <= pace + 3'h1;
        end
    end

    // one step every eight samples, always from the current code
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            applied_code <= RST_LEVEL;
        end else if (ramping && sample_tick && pace == 3'(RAMP_SAMPLES - 1)) begin
            if (applied_code < goal) begin
                applied_code <= applied_code + 8'h01;
            end else if (applied_code > floor_code || goal > floor_code) begin
                applied_code <= applied_code - 8'h01;
            end else begin
                applied_code <= floor_code;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    property p_step_paced;
        @(posedge clk) disable iff (!rst_n)
        (applied_code != $past(applied_code)) |-> $past(sample_tick) && $past(pace) == 3'h7;
    endproperty
    a_step_paced: assert property (p_step_paced) else $error("step off sample pace");

    property p_one_step;
        @(posedge clk) disable iff (!rst_n)
        $changed(applied_code) |-> (applied_code == $past(applied_code) + 8'h01)
                                 || (applied_code == $past(applied_code) - 8'h01);
    endproperty
    a_one_step: assert property (p_one_step) else $error("attenuator jumped");

    property p_idle_holds;
        @(posedge clk) disable iff (!rst_n)
        !ramping && $stable(goal) |=> $stable(applied_code);
    endproperty
    a_idle_holds: assert property (p_idle_holds) else $error("level moved while idle");
endmodule

// ==== src/dmra_top.sv ====
// mode register bank with serial control port and per-channel attenuator ramps
// assumes port pins already synchronous to clk; sample_tick is one pulse per sample
`timescale 1ns/1ps
module dmra_top
    import dmra_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       port_select_n,            // serial select, low frames a word
    input  wire logic       port_shift_clock,         // serial shift clock
    input  wire logic       port_serial_in,           // serial data, msb first
    input  wire logic       sample_tick,              // one pulse per sample period
    output logic      [7:0] left_applied_code,        // left code in effect
    output logic      [7:0] right_applied_code,       // right code in effect
    output logic            left_muted,               // left at infinite attenuation
    output logic            right_muted,              // right at infinite attenuation
    output logic            left_ramping,             // left still moving
    output logic            right_ramping,            // right still moving
    output logic            left_converter_disable,   // left output held at common level
    output logic            right_converter_disable,  // right output held at common level
    output logic            deemph_enable,            // de-emphasis on
    output logic      [1:0] deemph_rate_select,       // 00 44.1k, 01 48k, 10 32k
    output logic      [2:0] audio_word_layout,        // input format code
    output logic            format_valid,             // layout code not reserved
    output logic            rolloff_select,           // 1 slow rolloff
    output logic            atten_range_select,       // 1 wide range
    output logic            oversample_double,        // doubled oversampling
    output logic            output_phase_invert,      // inverted analog phase
    output logic            zero_flag_polarity,       // 1 flags active low
    output logic            zero_flag_combine,        // 1 common zero flag
    output logic            reinit_busy               // soft reinit in progress
);
    ////////////////////////////////////////////////////////////////
    // reset synchroniser
    logic rst_meta;   // first stage, read only by rst_n
    logic rst_n;      // released reset used everywhere

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////
    // serial control port, pins sampled directly on clk
    logic [WORD_BITS-1:0] shift_word;   // bits gathered in this frame
    logic [4:0]           bit_count;    // shift clocks seen in frame
    logic                 prev_sclk;    // last shift clock level
    logic                 prev_sel_n;   // last select level
    logic                 commit;       // rising select ends the frame
    logic [6:0]           word_index;   // index of the finished word
    logic [7:0]           word_data;    // data byte of the finished word
    logic                 word_ok;      // whole, well formed word

    // shift on rising shift clock while selected, msb first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_word <= '0;
            bit_count  <= 5'h00;
            prev_sclk  <= 1'b0;
            prev_sel_n <= 1'b1;
        end else begin
            prev_sclk  <= port_shift_clock;
            prev_sel_n <= port_select_n;
            if (port_select_n) begin
                bit_count <= 5'h00;
            end else if (port_shift_clock && !prev_sclk) begin
                shift_word <= {shift_word[WORD_BITS-2:0], port_serial_in};
                if (bit_count != 5'h1f) begin
                    bit_count <= bit_count + 5'h01;
                end
            end
        end
    end

    assign commit     = port_select_n && !prev_sel_n;
    assign word_index = shift_word[IDX_MSB:IDX_LSB];
    assign word_data  = shift_word[7:0];
    // a short frame or a set top bit is dropped
    assign word_ok    = commit && bit_count >= 5'(WORD_BITS)
                        && !shift_word[TOP_BIT];

    ////////////////////////////////////////////////////////////////
    // soft reinit counter
    logic [10:0] reinit_count;   // clocks left of soft reinit
    logic        reinit_start;   // reinit bit written as one

    assign reinit_start = word_ok && word_index == IDX_MUTE && word_data[REINIT_BIT];
    assign reinit_busy  = reinit_count != 11'h000;

    // holds registers at defaults for the reinit period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reinit_count <= 11'h000;
        end else if (reinit_start) begin
            reinit_count <= 11'(REINIT_CLOCKS);
        end else if (reinit_busy) begin
            reinit_count <= reinit_count - 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////
    // mode register file, write only
    logic [7:0] left_level;          // left level code
    logic [7:0] right_level;         // right level code
    logic [7:0] mute_reinit_rate;    // soft mute and oversampling
    logic [7:0] deemph_converter_ctl;
    logic [7:0] format_rolloff;
    logic [7:0] atten_range;
    logic [7:0] phase_zero_flag_ctl;

    // one write port; reserved bits are masked so they always read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_level           <= RST_LEVEL;
            right_level          <= RST_LEVEL;
            mute_reinit_rate     <= RST_MUTE;
            deemph_converter_ctl <= RST_DEEMPH;
            format_rolloff       <= RST_FORMAT;
            atten_range          <= RST_RANGE;
            phase_zero_flag_ctl  <= RST_PHASE;
        end else if (reinit_start || reinit_busy) begin
            left_level           <= RST_LEVEL;
            right_level          <= RST_LEVEL;
            mute_reinit_rate     <= RST_MUTE;
            deemph_converter_ctl <= RST_DEEMPH;
            format_rolloff       <= RST_FORMAT;
            atten_range          <= RST_RANGE;
            phase_zero_flag_ctl  <= RST_PHASE;
        end else if (word_ok) begin
            unique case (word_index)
                IDX_LEFT_LEVEL:  left_level  <= word_data;
                IDX_RIGHT_LEVEL: right_level <= word_data;
                IDX_MUTE:        mute_reinit_rate     <= word_data & MASK_MUTE & 8'h7f;
                IDX_DEEMPH:      deemph_converter_ctl <= word_data & MASK_DEEMPH;
                IDX_FORMAT:      format_rolloff       <= word_data & MASK_FORMAT;
                IDX_RANGE:       atten_range          <= word_data & MASK_RANGE;
                IDX_PHASE:       phase_zero_flag_ctl  <= word_data & MASK_PHASE;
                default:         ;   // any other index writes nothing
            endcase
        end
    end

    // decoded fields
    assign left_converter_disable  = deemph_converter_ctl[0];
    assign right_converter_disable = deemph_converter_ctl[1];
    assign deemph_enable           = deemph_converter_ctl[4];
    assign deemph_rate_select      = deemph_converter_ctl[6:5];
    assign audio_word_layout       = format_rolloff[2:0];
    assign format_valid            = format_rolloff[2:1] != 2'b11;
    assign rolloff_select          = format_rolloff[5];
    assign atten_range_select      = atten_range[0];
    assign oversample_double       = mute_reinit_rate[OVER_BIT];
    assign output_phase_invert     = phase_zero_flag_ctl[0];
    assign zero_flag_polarity      = phase_zero_flag_ctl[1];
    assign zero_flag_combine       = phase_zero_flag_ctl[2];

    ////////////////////////////////////////////////////////////////
    // one independent ramp per channel; the converter applies step times code minus 255
    dmra_ramp u_left (
        .clk          (clk),
        .rst_n        (rst_n),
        .sample_tick  (sample_tick),
        .target_code  (left_level),
        .silence      (mute_reinit_rate[MUTE_LEFT_BIT]),
        .wide_range   (atten_range_select),
        .applied_code (left_applied_code),
        .applied_mute (left_muted),
        .ramping      (left_ramping)
    );

    dmra_ramp u_right (
        .clk          (clk),
        .rst_n        (rst_n),
        .sample_tick  (sample_tick),
        .target_code  (right_level),
        .silence      (mute_reinit_rate[MUTE_RIGHT_BIT]),
        .wide_range   (atten_range_select),
        .applied_code (right_applied_code),
        .applied_mute (right_muted),
        .ramping      (right_ramping)
    );

    ////////////////////////////////////////////////////////////////
    sequence s_left_write;
        word_ok && word_index == IDX_LEFT_LEVEL && !reinit_busy;
    endsequence

    property p_left_commit;
        @(posedge clk) disable iff (!rst_n)
        s_left_write |=> left_level == $past(word_data);
    endproperty
    a_left_commit: assert property (p_left_commit) else $error("left level not stored");

    property p_bad_word_ignored;
        @(posedge clk) disable iff (!rst_n)
        commit && !word_ok && !reinit_busy |=> $stable(right_level) && $stable(atten_range)
                                            && $stable(format_rolloff) && $stable(left_level);
    endproperty
    a_bad_word_ignored: assert property (p_bad_word_ignored) else $error("bad word wrote");

    property p_independent;
        @(posedge clk) disable iff (!rst_n)
        word_ok && word_index == IDX_LEFT_LEVEL |=> $stable(right_level);
    endproperty
    a_independent: assert property (p_independent) else $error("right touched");

    property p_reinit_len;
        @(posedge clk) disable iff (!rst_n)
        reinit_start ##1 !reinit_start [*8] |-> reinit_busy;
    endproperty
    a_reinit_len: assert property (p_reinit_len) else $error("reinit too short");

    property p_reinit_defaults;
        @(posedge clk) disable iff (!rst_n)
        reinit_start |=> left_level == RST_LEVEL && format_rolloff == RST_FORMAT;
    endproperty
    a_reinit_defaults: assert property (p_reinit_defaults) else $error("reinit left state");

    // a left mute request whose ramp has come to rest must leave the channel silent
    property p_mute_reaches;
        @(posedge clk) disable iff (!rst_n)
        mute_reinit_rate[MUTE_LEFT_BIT] && !left_ramping |-> left_muted;
    endproperty
    a_mute_reaches: assert property (p_mute_reaches) else $error("mute not reached");
endmodule

// ==== dv/dmra_host.sv ====
// host model: drives the three-wire serial control port of the register bank
// assumes clk is the device clock; pins change only just after its rising edge
`timescale 1ns/1ps
module dmra_host (
    input  wire logic clk,
    output logic      port_select_n,
    output logic      port_shift_clock,
    output logic      port_serial_in
);
    // idle: select high, shift clock parked low between frames
    initial begin
        port_select_n    = 1'b1;
        port_shift_clock = 1'b0;
        port_serial_in   = 1'b0;
    end
    ////////////////////////////////////////
    // one frame msb first; nbits below 16 gives a short frame on purpose
    // slow stretches every shift clock level, each level lasts at least two clocks
    task automatic send(input logic [15:0] word, input int nbits, input int slow);
        @(posedge clk) port_select_n <= 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            port_serial_in   <= word[i];
            port_shift_clock <= 1'b0;
            repeat (2 + slow) @(posedge clk);
            port_shift_clock <= 1'b1;
            repeat (2 + slow) @(posedge clk);
        end
        port_shift_clock <= 1'b0;
        repeat (2) @(posedge clk);
        port_select_n  <= 1'b1;
        // line is undriven once deselected: show the inverse, not a held bit
        port_serial_in <= ~word[16 - nbits];
        repeat (3 + slow) @(posedge clk);
    endtask
endmodule

// ==== dv/test_dac_mode_regs_attenuator.sv ====
// self-checking bench for the mode register bank and attenuator ramps
// assumes dmra_host drives the port; sample strobe every other clock
`timescale 1ns/1ps
module test_dac_mode_regs_attenuator
    import dmra_pkg::*;
;
    logic       clk, rstn, sample_tick;
    wire logic  port_select_n, port_shift_clock, port_serial_in;
    logic [7:0] left_applied_code, right_applied_code;
    logic       left_muted, right_muted, left_ramping, right_ramping, reinit_busy, format_valid;
    logic       left_converter_disable, right_converter_disable, deemph_enable, rolloff_select;
    logic       atten_range_select, oversample_double, output_phase_invert;
    logic       zero_flag_polarity, zero_flag_combine;
    logic [1:0] deemph_rate_select;
    logic [2:0] audio_word_layout;
    logic [7:0] rm [7];     // expected register contents, index minus 10h
    logic [7:0] ec [2];     // expected settled applied codes
    logic [7:0] pc [2];     // applied codes seen at the previous edge
    int         tk [2];     // ticks counted while ramping
    logic       pb;         // reinit busy at the previous edge
    int         num_errors, num_checks, cyc, busy_len;
    logic [31:0] seed;
    wire logic [13:0] fields = {left_converter_disable, right_converter_disable, deemph_enable,
        deemph_rate_select, audio_word_layout, rolloff_select, atten_range_select,
        oversample_double, output_phase_invert, zero_flag_polarity, zero_flag_combine};

    dmra_top i_dmra_top (.clk, .rstn, .port_select_n, .port_shift_clock, .port_serial_in,
        .sample_tick, .left_applied_code, .right_applied_code, .left_muted, .right_muted,
        .left_ramping, .right_ramping, .left_converter_disable, .right_converter_disable,
        .deemph_enable, .deemph_rate_select, .audio_word_layout, .format_valid, .rolloff_select,
        .atten_range_select, .oversample_double, .output_phase_invert, .zero_flag_polarity,
        .zero_flag_combine, .reinit_busy);
    dmra_host i_dmra_host (.clk, .port_select_n, .port_shift_clock, .port_serial_in);

    ////////////////////////////////////////
    // xorshift source, fixed seed so runs repeat
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // fields in the order of the bench's field vector
    function automatic logic [13:0] exp_fields();
        return {rm[3][0], rm[3][1], rm[3][4], rm[3][6:5], rm[4][2:0], rm[4][5], rm[5][0],
                rm[2][6], rm[6][0], rm[6][1], rm[6][2]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic model_reset();
        rm = '{RST_LEVEL, RST_LEVEL, RST_MUTE, RST_DEEMPH, RST_FORMAT, RST_RANGE, RST_PHASE};
        ec = '{8'hff, 8'hff};
    endtask
    // write one register; reserved bits go out as zero, the reinit bit is never kept
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        logic [7:0] m [7];
        int         k;
        m = '{8'hff, 8'hff, MASK_MUTE, MASK_DEEMPH, MASK_FORMAT, MASK_RANGE, MASK_PHASE};
        k = int'(idx) - 16;
        i_dmra_host.send({1'b0, idx, d & m[k]}, 16, int'(rnd() % 3));
        if (k == 2 && d[REINIT_BIT]) model_reset();
        else if (!reinit_busy) rm[k] = d & m[k] & ((k == 2) ? 8'h7f : 8'hff);
    endtask
    // wait for both ramps and any reinit to finish, then compare everything
    task automatic settle_check();
        int         n;
        logic [7:0] f, g0, g1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((left_ramping !== 1'b0 || right_ramping !== 1'b0 || reinit_busy !== 1'b0)
                   && n < 9000);
        if (n >= 9000) begin
            chk(16'h0, 16'h1);
            report_and_stop();
        end
        f  = rm[5][0] ? WIDE_MUTE_TOP : FINE_MUTE_TOP;
        g0 = (rm[2][0] || rm[0] <= f) ? f : rm[0];
        g1 = (rm[2][1] || rm[1] <= f) ? f : rm[1];
        // a code already at or under the floor counts as arrived at mute
        if (!(g0 == f && ec[0] <= f)) ec[0] = g0;
        if (!(g1 == f && ec[1] <= f)) ec[1] = g1;
        chk({left_applied_code, right_applied_code}, {ec[0], ec[1]});
        chk({left_muted, right_muted}, {ec[0] <= f, ec[1] <= f});
        chk({fields, format_valid}, {exp_fields(), rm[4][2:1] != 2'b11});
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    // clock, sample strobe every other cycle, watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // step pacing and size per channel, reinit length, cycle ceiling
    always @(posedge clk) begin
        logic [7:0] cc [2];
        logic       rp [2];
        cc = '{left_applied_code, right_applied_code};
        rp = '{left_ramping, right_ramping};
        for (int c = 0; c < 2; c++) begin
            if (cc[c] !== pc[c] && rstn && !pb && !reinit_busy) begin
                chk(16'(tk[c]), 16'd8);
                chk({15'h0, cc[c] - pc[c] == 8'h01 || pc[c] - cc[c] == 8'h01}, 16'h1);
                tk[c] = 0;
            end
            if (!rp[c] || reinit_busy) tk[c] = 0;
            else if (sample_tick) tk[c]++;
        end
        if (reinit_busy) busy_len++;
        else if (busy_len != 0) begin
            chk(16'(busy_len), 16'd1024);
            busy_len = 0;
        end
        pc = cc;
        pb = reinit_busy;
        cyc++;
        if (cyc == 60000) begin
            chk(16'h0, 16'h1);
            report_and_stop();
        end
    end
    always @(posedge clk) sample_tick <= ~sample_tick;

    ////////////////////////////////////////
    // main sequence: reset, field registers, refusals, ramps, reinit, random writes
    initial begin
        logic [7:0] d;
        logic [7:0] lv [4];
        logic [6:0] ix [4];
        lv = '{8'h80, 8'h81, 8'h9a, 8'h9b};
        ix = '{IDX_LEFT_LEVEL, IDX_RIGHT_LEVEL, IDX_MUTE, IDX_RANGE};
        seed = 32'h31add23e;
        num_errors = 0;
        num_checks = 0;
        cyc = 0;
        busy_len = 0;
        tk = '{0, 0};
        pb = 1'b0;
        sample_tick = 1'b0;
        rstn = 1'b0;
        model_reset();
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        settle_check();
        for (int f = 0; f < 8; f++) begin
            wr(IDX_FORMAT, 8'(f) | 8'h20);
            settle_check();
        end
        for (int i = 0; i < 6; i++) begin
            wr(IDX_DEEMPH + 7'(i % 4), 8'(rnd()));
            settle_check();
        end
        // top bit set, index above and below the bank, short frame: all refused
        for (int b = 0; b < 4; b++) begin
            d = rm[4] ^ 8'h24;
            i_dmra_host.send({b == 0, b == 1 ? 7'h17 : b == 2 ? 7'h0f : IDX_FORMAT, d},
                             b == 3 ? 12 : 16, 0);
            settle_check();
        end
        // mute arrives mid-ramp and carries it on down to the floor; right stays put
        wr(IDX_RANGE, 8'h00);
        settle_check();
        wr(IDX_LEFT_LEVEL, 8'hc0);
        repeat (200) @(posedge clk);
        chk({7'h0, right_ramping, right_applied_code}, {7'h0, 1'b0, ec[1]});
        wr(IDX_MUTE, 8'h01);
        settle_check();
        wr(IDX_MUTE, 8'h00);
        settle_check();
        // mute thresholds on both sides of each floor
        for (int i = 0; i < 8; i++) begin
            wr(IDX_RANGE, 8'(i / 4));
            wr(IDX_LEFT_LEVEL, lv[i % 4]);
            settle_check();
        end
        // soft reinit mid-ramp; a write while busy is dropped
        wr(IDX_RIGHT_LEVEL, 8'h90);
        wr(IDX_MUTE, 8'h80);
        wr(IDX_RANGE, 8'h01);
        chk({15'h0, reinit_busy}, 16'h1);
        settle_check();
        for (int i = 0; i < 10; i++) begin
            d = 8'(rnd());
            b_sel: begin
                int k;
                k = int'(rnd() % 4);
                wr(ix[k], (k == 2) ? d & 8'h7f : d);
            end
            settle_check();
        end
        report_and_stop();
    end
endmodule
